// File: cpt_timer_pwm_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Two channels; second works as software compare
// - Routing bit feeds comparator to capture zero
// - Clock select both ones uses external pin
// - External clock tick shared with other timers
// - Free-running buffered update at FFFE to FFFF
// - Centre select bit enables up/down counting
// - Count up to modulus, down to zero
// - Centre period is twice the modulus
// - Centre pulse width is twice channel value
// - Zero value, or negative one in centre mode, gives 0% duty
// - Value above nonzero modulus gives 100% duty
// - Zero modulus, edge mode: free run wrap
// - Edge-level select A sets output polarity
// - Level A zero: up-match low, down-match high
module cpt_timer_pwm_unit
   import cpt_pkg::*;
#(
   parameter int unsigned CNT_W = 16,
   parameter int unsigned NCH   = 2
)
(
   input  wire logic             CLK,
   input  wire logic             RST_B,
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [7:0]       PADDR,
   input  wire logic [31:0]      PWDATA,
   output logic                  PREADY,
   output logic [31:0]           PRDATA,
   output logic                  PSLVERR,
   input  wire logic             EXTERNAL_TIMER_CLOCK_PIN,
   output logic                  TIMER_EXTERNAL_CLOCK_TICK,
   input  wire logic             ANALOG_COMPARATOR_OUT,
   input  wire logic [NCH-1:0]   TIMER_CHANNEL_PIN_IN,
   output logic [NCH-1:0]        TIMER_CHANNEL_PIN_OUT,
   output logic [NCH-1:0]        TIMER_CHANNEL_PIN_OE
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [1:0]           clk_sel_reg;
   logic                 center_reg;
   logic                 ovf_flag_reg;
   logic                 route_reg;
   logic [CNT_W-1:0]     mod_buf_reg;
   logic [CNT_W-1:0]     mod_act_reg;
   logic [CNT_W-1:0]     cnt_reg;
   logic [CNT_W-1:0]     cnt_next;
   logic                 dir_down_reg;
   logic                 dir_down_next;
   logic                 ext_pin_reg;
   logic                 tick;
   logic                 load_evt;
   logic                 turn_evt;
   logic [31:0]          prdata_reg;
   logic                 pslverr_reg;
   logic                 setup;
   logic                 wr_acc;
   cpt_chan_cfg_t        cfg_reg   [NCH];
   logic [CNT_W-1:0]     val_buf_reg [NCH];
   logic [CNT_W-1:0]     val_act_reg [NCH];
   logic [NCH-1:0]       ch_flag_reg;
   logic [NCH-1:0]       out_reg;
   logic [NCH-1:0]       cap_src_reg;
   logic [NCH-1:0]       cap_src;
   logic [NCH-1:0]       cap_evt;
   logic [NCH-1:0]       match;

   // Decode of a channel register address, used by read and write
   function automatic logic chan_hit(input logic [7:0] addr, input int unsigned ch,
                                     input logic [7:0] sub);
      logic [7:0] base;
      base = OFF_CHAN_BASE + 8'(ch) * OFF_CHAN_STRIDE + sub;
      return addr == base;
   endfunction

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign setup   = PSEL && !PENABLE;
   assign wr_acc  = PSEL && PENABLE && PWRITE;
   assign PREADY  = 1'b1;       // Zero wait states
   assign PRDATA  = prdata_reg;
   assign PSLVERR = pslverr_reg;

   // Read data captured in setup so the answer comes from a flop
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setup)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b1;
         if (PADDR == OFF_STATUS_CONTROL)
         begin
            prdata_reg[POS_CLK_SEL +: 2] <= clk_sel_reg;
            prdata_reg[POS_CENTER]       <= center_reg;
            prdata_reg[POS_OVF_FLAG]     <= ovf_flag_reg;
            pslverr_reg                  <= 1'b0;
         end
         if (PADDR == OFF_MODULUS)
         begin
            prdata_reg[CNT_W-1:0] <= mod_buf_reg;
            pslverr_reg           <= 1'b0;
         end
         if (PADDR == OFF_COUNT)
         begin
            prdata_reg[CNT_W-1:0]    <= cnt_reg;
            prdata_reg[POS_DIR_DOWN] <= dir_down_reg;
            pslverr_reg              <= 1'b0;
         end
         if (PADDR == OFF_SYSTEM_OPTIONS)
         begin
            prdata_reg[POS_ROUTE] <= route_reg;
            pslverr_reg           <= 1'b0;
         end
         for (int unsigned i = 0; i < NCH; i++)
         begin
            if (chan_hit(PADDR, i, 8'h00))
            begin
               prdata_reg[POS_ELSA]    <= cfg_reg[i].elsa;
               prdata_reg[POS_OUT_EN]  <= cfg_reg[i].out_en;
               prdata_reg[POS_CAPTURE] <= cfg_reg[i].capture;
               prdata_reg[POS_CH_FLAG] <= ch_flag_reg[i];
               pslverr_reg             <= 1'b0;
            end
            if (chan_hit(PADDR, i, OFF_CHAN_VALUE))
            begin
               prdata_reg[CNT_W-1:0] <= val_buf_reg[i];
               pslverr_reg           <= 1'b0;
            end
         end
      end
   end

   // Control and option registers
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         clk_sel_reg <= CLK_OFF;
         center_reg  <= 1'b0;
         route_reg   <= 1'b0;
      end
      else if (wr_acc)
      begin
         if (PADDR == OFF_STATUS_CONTROL)
         begin
            clk_sel_reg <= PWDATA[POS_CLK_SEL +: 2];
            center_reg  <= PWDATA[POS_CENTER];
         end
         if (PADDR == OFF_SYSTEM_OPTIONS)
            route_reg <= PWDATA[POS_ROUTE];
      end
   end

   // ------------------------------------------------------------
   // Clock source
   // ------------------------------------------------------------
   // Pin is taken as synchronous; one flop for edge detection
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         ext_pin_reg <= 1'b0;
      else
         ext_pin_reg <= EXTERNAL_TIMER_CLOCK_PIN;
   end

   // Tick is exported so the sibling timer and modulo timer share it
   assign TIMER_EXTERNAL_CLOCK_TICK = EXTERNAL_TIMER_CLOCK_PIN && !ext_pin_reg;

   // Fixed-rate source not modelled here, so it runs at bus rate
   always_comb
   begin
      unique case (clk_sel_reg)
         CLK_OFF:      tick = 1'b0;
         CLK_BUS:      tick = 1'b1;
         CLK_FIXED:    tick = 1'b1;
         CLK_EXTERNAL: tick = TIMER_EXTERNAL_CLOCK_TICK;
      endcase
   end

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   always_comb
   begin
      cnt_next      = cnt_reg + CNT_W'(1);
      dir_down_next = dir_down_reg;
      turn_evt      = 1'b0;
      if (center_reg)
      begin
         if (!dir_down_reg && cnt_reg == mod_act_reg && mod_act_reg != '0)
         begin
            dir_down_next = 1'b1;
            cnt_next      = cnt_reg - CNT_W'(1);
            turn_evt      = 1'b1;
         end
         else if (dir_down_reg && cnt_reg == '0)
         begin
            dir_down_next = 1'b0;
            turn_evt      = 1'b1;
         end
         else if (dir_down_reg)
            cnt_next = cnt_reg - CNT_W'(1);
      end
      else
      begin
         dir_down_next = 1'b0;
         if (cnt_reg == mod_act_reg && mod_act_reg != '0)
         begin
            cnt_next = '0;
            turn_evt = 1'b1;
         end
         else if (cnt_reg == CNT_TOP)
            turn_evt = 1'b1;
      end
   end

   // Counter state; a write to the count register restarts it
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cnt_reg      <= '0;
         dir_down_reg <= 1'b0;
      end
      else if (wr_acc && PADDR == OFF_COUNT)
      begin
         cnt_reg      <= '0;
         dir_down_reg <= 1'b0;
      end
      else if (tick)
      begin
         cnt_reg      <= cnt_next;
         dir_down_reg <= dir_down_next;
      end
   end

   // Overflow flag: hardware set wins over the write-one clear
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         ovf_flag_reg <= 1'b0;
      else if (tick && turn_evt)
         ovf_flag_reg <= 1'b1;
      else if (wr_acc && PADDR == OFF_STATUS_CONTROL && PWDATA[POS_OVF_FLAG])
         ovf_flag_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // Buffered modulus and channel values
   // ------------------------------------------------------------
   // Loading at the cycle boundary, or at once while stopped, avoids glitched periods
   always_comb
   begin
      if (clk_sel_reg == CLK_OFF)
         load_evt = 1'b1;
      else if (!center_reg && mod_act_reg == '0)
         load_evt = tick && cnt_reg == CNT_PRE_TOP;
      else
         load_evt = tick && turn_evt;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mod_buf_reg <= RST_MODULUS;
         mod_act_reg <= RST_MODULUS;
      end
      else
      begin
         if (wr_acc && PADDR == OFF_MODULUS)
            mod_buf_reg <= PWDATA[CNT_W-1:0];
         if (load_evt)
            mod_act_reg <= mod_buf_reg;
      end
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_chan
         // Channel zero may listen to the comparator instead of its pin
         if (g == 0)
         begin : g_route
            assign cap_src[g] = route_reg ? ANALOG_COMPARATOR_OUT
                                          : TIMER_CHANNEL_PIN_IN[g];
            assign TIMER_CHANNEL_PIN_OE[g] = cfg_reg[g].out_en && !cfg_reg[g].capture
                                             && !route_reg;
         end
         else
         begin : g_plain
            assign cap_src[g] = TIMER_CHANNEL_PIN_IN[g];
            assign TIMER_CHANNEL_PIN_OE[g] = cfg_reg[g].out_en && !cfg_reg[g].capture;
         end

         assign cap_evt[g] = cfg_reg[g].capture && cap_src[g] && !cap_src_reg[g];
         // Compare works with no pin, so it serves as software compare
         assign match[g]   = tick && !cfg_reg[g].capture && cnt_reg == val_act_reg[g];
         assign TIMER_CHANNEL_PIN_OUT[g] = out_reg[g];

         // Configuration and value buffer; capture overrides software
         always_ff @(posedge CLK or negedge RST_B)
         begin
            if (!RST_B)
            begin
               cfg_reg[g]     <= RST_CHAN_CFG;
               val_buf_reg[g] <= RST_VALUE;
               val_act_reg[g] <= RST_VALUE;
            end
            else
            begin
               if (wr_acc && chan_hit(PADDR, g, 8'h00))
               begin
                  cfg_reg[g].elsa    <= PWDATA[POS_ELSA];
                  cfg_reg[g].out_en  <= PWDATA[POS_OUT_EN];
                  cfg_reg[g].capture <= PWDATA[POS_CAPTURE];
               end
               if (cap_evt[g])
               begin
                  val_buf_reg[g] <= cnt_reg;
                  val_act_reg[g] <= cnt_reg;
               end
               else
               begin
                  if (wr_acc && chan_hit(PADDR, g, OFF_CHAN_VALUE))
                     val_buf_reg[g] <= PWDATA[CNT_W-1:0];
                  if (load_evt)
                     val_act_reg[g] <= val_buf_reg[g];
               end
            end
         end

         // Capture input history and event flag
         always_ff @(posedge CLK or negedge RST_B)
         begin
            if (!RST_B)
            begin
               cap_src_reg[g] <= 1'b0;
               ch_flag_reg[g] <= 1'b0;
            end
            else
            begin
               cap_src_reg[g] <= cap_src[g];
               if (cap_evt[g] || match[g])
                  ch_flag_reg[g] <= 1'b1;
               else if (wr_acc && chan_hit(PADDR, g, 8'h00) && PWDATA[POS_CH_FLAG])
                  ch_flag_reg[g] <= 1'b0;
            end
         end

         // Output level; inactive level equals the polarity bit
         always_ff @(posedge CLK or negedge RST_B)
         begin
            if (!RST_B)
               out_reg[g] <= 1'b0;
            else if (center_reg)
            begin
               if (val_act_reg[g] == '0 || val_act_reg[g][CNT_W-1])
                  out_reg[g] <= cfg_reg[g].elsa;
               else if (mod_act_reg != '0 && val_act_reg[g] > mod_act_reg)
                  out_reg[g] <= !cfg_reg[g].elsa;
               else if (match[g] && !dir_down_reg)
                  out_reg[g] <= cfg_reg[g].elsa;
               else if (match[g] && dir_down_reg)
                  out_reg[g] <= !cfg_reg[g].elsa;
            end
            else
               // Edge-aligned: active while count is below the value
               out_reg[g] <= (cnt_reg < val_act_reg[g]) ^ cfg_reg[g].elsa;
         end
      end
   endgenerate

endmodule // cpt_timer_pwm_unit

`default_nettype wire

// File: cpt_pkg.sv
package cpt_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] OFF_MODULUS        = 8'h04;
   localparam logic [7:0] OFF_COUNT          = 8'h08;
   localparam logic [7:0] OFF_SYSTEM_OPTIONS = 8'h0C;
   localparam logic [7:0] OFF_CHAN_BASE      = 8'h10;
   localparam logic [7:0] OFF_CHAN_STRIDE    = 8'h08;
   localparam logic [7:0] OFF_CHAN_VALUE     = 8'h04;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned POS_CLK_SEL   = 0;
   localparam int unsigned POS_CENTER    = 2;
   localparam int unsigned POS_OVF_FLAG  = 8;
   localparam int unsigned POS_DIR_DOWN  = 16;
   localparam int unsigned POS_ROUTE     = 0;
   localparam int unsigned POS_ELSA      = 0;
   localparam int unsigned POS_OUT_EN    = 1;
   localparam int unsigned POS_CAPTURE   = 2;
   localparam int unsigned POS_CH_FLAG   = 7;

   // ------------------------------------------------------------
   // Clock source selections, reset values and counter top values
   // ------------------------------------------------------------
   localparam logic [1:0]  CLK_OFF      = 2'h0;
   localparam logic [1:0]  CLK_BUS      = 2'h1;
   localparam logic [1:0]  CLK_FIXED    = 2'h2;
   localparam logic [1:0]  CLK_EXTERNAL = 2'h3;
   localparam logic [15:0] RST_MODULUS  = 16'h0000;
   localparam logic [15:0] RST_VALUE    = 16'h0000;
   localparam logic [15:0] CNT_TOP      = 16'hFFFF;
   localparam logic [15:0] CNT_PRE_TOP  = 16'hFFFE;

   // Per-channel configuration
   typedef struct packed {
      logic capture;
      logic out_en;
      logic elsa;
   } cpt_chan_cfg_t;

   localparam cpt_chan_cfg_t RST_CHAN_CFG = '{capture: 1'b0, out_en: 1'b0, elsa: 1'b0};

endpackage

// File: cpt_pwm_props.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_pwm_props
   import cpt_pkg::*;
#(parameter int unsigned NCH = 2)
(
   input wire logic             CLK,
   input wire logic             RST_B,
   input wire logic             PSEL,
   input wire logic             PENABLE,
   input wire logic             PWRITE,
   input wire logic [7:0]       PADDR,
   input wire logic [31:0]      PWDATA,
   input wire logic             PREADY,
   input wire logic [31:0]      PRDATA,
   input wire logic             PSLVERR,
   input wire logic             EXTERNAL_TIMER_CLOCK_PIN,
   input wire logic             TIMER_EXTERNAL_CLOCK_TICK,
   input wire logic             ANALOG_COMPARATOR_OUT,
   input wire logic [NCH-1:0]   TIMER_CHANNEL_PIN_IN,
   input wire logic [NCH-1:0]   TIMER_CHANNEL_PIN_OUT,
   input wire logic [NCH-1:0]   TIMER_CHANNEL_PIN_OE
);
   // ----------------------------------------
   // Register shadows
   // ----------------------------------------
   logic        wr_en;
   logic [2:0]  sc_reg, cfg0_reg, cfg1_reg;
   logic [15:0] mod_reg, val0_reg;
   logic        route_reg, setup_reg;
   logic [7:0]  addr_reg, quiet_reg;
   assign wr_en = PSEL && PENABLE && PWRITE && PREADY;

   // Shadow copies, so rules can be checked from the pins alone
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         sc_reg <= 3'h0; cfg0_reg <= 3'h0; cfg1_reg <= 3'h0;
         mod_reg <= 16'h0000; val0_reg <= 16'h0000; route_reg <= 1'b0;
      end
      else if (wr_en)
         case (PADDR)
            8'h00: sc_reg <= PWDATA[2:0];
            8'h04: mod_reg <= PWDATA[15:0];
            8'h0C: route_reg <= PWDATA[0];
            8'h10: cfg0_reg <= PWDATA[2:0];
            8'h14: val0_reg <= PWDATA[15:0];
            8'h18: cfg1_reg <= PWDATA[2:0];
            default: ;
         endcase

   // Quiet time since last write; buffered values need a full period to land
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         setup_reg <= 1'b0; addr_reg <= 8'h00; quiet_reg <= 8'h00;
      end
      else
      begin
         setup_reg <= PSEL && !PENABLE;
         addr_reg <= PADDR;
         quiet_reg <= wr_en ? 8'h00 : (quiet_reg == 8'hFF ? quiet_reg : quiet_reg + 8'h01);
      end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic steady;
   assign steady = quiet_reg == 8'hFF && sc_reg == 3'h5 && mod_reg != 16'h0000
                   && mod_reg < 16'h0040;

   property p_tick;
      $past(RST_B) |-> TIMER_EXTERNAL_CLOCK_TICK ==
         (EXTERNAL_TIMER_CLOCK_PIN && !$past(EXTERNAL_TIMER_CLOCK_PIN));
   endproperty
   a_tick: assert property (p_tick) else $error("external tick wrong");
   property p_oe0;
      TIMER_CHANNEL_PIN_OE[0] == (cfg0_reg[1] && !cfg0_reg[2] && !route_reg);
   endproperty
   a_oe0: assert property (p_oe0) else $error("channel 0 enable wrong");
   property p_oe1;
      TIMER_CHANNEL_PIN_OE[1] == (cfg1_reg[1] && !cfg1_reg[2]);
   endproperty
   a_oe1: assert property (p_oe1) else $error("channel 1 enable wrong");
   property p_zero;
      steady && (val0_reg == 16'h0000 || val0_reg[15]) |-> TIMER_CHANNEL_PIN_OUT[0] == cfg0_reg[0];
   endproperty
   a_zero: assert property (p_zero) else $error("zero duty output active");
   property p_full;
      steady && !val0_reg[15] && val0_reg > mod_reg |-> TIMER_CHANNEL_PIN_OUT[0] != cfg0_reg[0];
   endproperty
   a_full: assert property (p_full) else $error("full duty output idle");
   property p_err;
      setup_reg |-> PSLVERR == (addr_reg > 8'h1C || addr_reg[1:0] != 2'b00);
   endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_hold;
      !setup_reg |-> $stable(PRDATA) && $stable(PSLVERR);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_ready;
      PSEL && PENABLE |-> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");

   c_zero: cover property (steady && val0_reg == 16'h0000);
   c_unmapped: cover property (setup_reg && addr_reg > 8'h1C);
   c_ext: cover property (TIMER_EXTERNAL_CLOCK_TICK && sc_reg == 3'h7);
endmodule // cpt_pwm_props
`default_nettype wire

// File: cpt_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_load_model
(
   input wire logic    CLK,
   input wire logic    DRIVE_OUT,
   input wire logic    DRIVE_OE,
   input wire logic    EXT_EN,
   input wire logic    EXT_VAL,
   input wire logic    CLEAR,
   output logic        LEVEL,
   output var logic [15:0] HIGH_CNT,
   output var logic [15:0] PERIOD
);
   logic        prev_reg = 1'b0;
   logic [15:0] run_reg  = 16'h0000;
   // Pull-down on the load: an undriven line reads low
   assign LEVEL = DRIVE_OE ? DRIVE_OUT : (EXT_EN ? EXT_VAL : 1'b0);

   // Energised time of the load
   always_ff @(posedge CLK)
      HIGH_CNT <= CLEAR ? 16'h0000 : HIGH_CNT + {15'h0000, LEVEL};

   // Cycles between rising edges
   always_ff @(posedge CLK)
   begin
      prev_reg <= LEVEL;
      run_reg <= (LEVEL && !prev_reg) ? 16'h0001 : run_reg + 16'h0001;
      if (LEVEL && !prev_reg)
         PERIOD <= run_reg;
   end
endmodule // cpt_load_model
`default_nettype wire

// File: cpt_timer_pwm_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_pwm_unit_tb
   import cpt_pkg::*;
;
   localparam int unsigned NCH = 2;
   typedef struct packed {
      logic ch; logic [15:0] m; logic [15:0] v; logic e; logic [15:0] hi; logic [15:0] per;
   } cpt_row_t;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rd_err;
   logic ext_clk, tick_out, cmp_out;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd_data;
   logic [1:0]        pin_in, pin_out, pin_oe, ext_en, ext_val, clr;
   logic [1:0][15:0]  high_cnt, period;
   int n_errors, samples_checked;
   // Modulus kept in 1..0x7FFF and never zero in centre mode
   cpt_row_t rows [9] = '{
      '{1'b0, 16'h000A, 16'h0003, 1'b0, 16'h0006, 16'h0014},
      '{1'b0, 16'h000A, 16'h0003, 1'b1, 16'h000E, 16'h0014},
      '{1'b0, 16'h0007, 16'h0000, 1'b0, 16'h0000, 16'h0000},
      '{1'b0, 16'h0007, 16'h0000, 1'b1, 16'h000E, 16'h0000},
      '{1'b0, 16'h0005, 16'h8002, 1'b0, 16'h0000, 16'h0000},
      '{1'b0, 16'h0005, 16'h0009, 1'b0, 16'h000A, 16'h0000},
      '{1'b1, 16'h0005, 16'h0009, 1'b1, 16'h0000, 16'h0000},
      '{1'b1, 16'h0014, 16'h0013, 1'b0, 16'h0026, 16'h0028},
      '{1'b1, 16'h0008, 16'h0003, 1'b1, 16'h000A, 16'h0010}};
   logic [7:0] regs [6] = '{OFF_STATUS_CONTROL, OFF_MODULUS, OFF_COUNT,
                            OFF_SYSTEM_OPTIONS, OFF_CHAN_BASE, 8'h14};

   cpt_timer_pwm_unit #(.NCH(NCH)) u_dut (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .EXTERNAL_TIMER_CLOCK_PIN(ext_clk), .TIMER_EXTERNAL_CLOCK_TICK(tick_out),
      .ANALOG_COMPARATOR_OUT(cmp_out), .TIMER_CHANNEL_PIN_IN(pin_in),
      .TIMER_CHANNEL_PIN_OUT(pin_out), .TIMER_CHANNEL_PIN_OE(pin_oe));
   cpt_load_model u_load0 (.CLK(clk), .DRIVE_OUT(pin_out[0]), .DRIVE_OE(pin_oe[0]),
      .EXT_EN(ext_en[0]), .EXT_VAL(ext_val[0]), .CLEAR(clr[0]), .LEVEL(pin_in[0]),
      .HIGH_CNT(high_cnt[0]), .PERIOD(period[0]));
   cpt_load_model u_load1 (.CLK(clk), .DRIVE_OUT(pin_out[1]), .DRIVE_OE(pin_oe[1]),
      .EXT_EN(ext_en[1]), .EXT_VAL(ext_val[1]), .CLEAR(clr[1]), .LEVEL(pin_in[1]),
      .HIGH_CNT(high_cnt[1]), .PERIOD(period[1]));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 50)
         n_errors++;
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Stop the timer first so the buffered values load at once
   task automatic prog(input cpt_row_t r);
      logic [7:0] base;
      base = OFF_CHAN_BASE + (r.ch ? OFF_CHAN_STRIDE : 8'h00);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0000);
      apb(1'b1, OFF_MODULUS, {16'h0000, r.m});
      apb(1'b1, base, 32'h0000_0002 | {31'h0000_0000, r.e});
      apb(1'b1, base + OFF_CHAN_VALUE, {16'h0000, r.v});
      apb(1'b1, OFF_COUNT, 32'h0000_0000);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0005);
   endtask

   task automatic pulse(input int n);
      repeat (n)
      begin
         ext_clk <= 1'b1;
         repeat (2) @(posedge clk);
         ext_clk <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Whole sequence needs about 69000 cycles, mostly one free-run wrap
   initial
   begin
      repeat (90000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      {rst_b, psel, penable, pwrite, ext_clk, cmp_out} = 6'h00;
      {ext_en, ext_val, clr} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[i])
      begin
         prog(rows[i]);
         repeat (300) @(posedge clk);
         clr[rows[i].ch] <= 1'b1;
         @(posedge clk);
         clr[rows[i].ch] <= 1'b0;
         repeat (2 * rows[i].m) @(posedge clk);
         #1;
         chk("high cycles", {16'h0000, rows[i].hi}, {16'h0000, high_cnt[rows[i].ch]});
         if (rows[i].per != 16'h0000)
            chk("period", {16'h0000, rows[i].per}, {16'h0000, period[rows[i].ch]});
      end
      // External pin clocks the counter: up to 4, down, back up
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0000);
      apb(1'b1, OFF_MODULUS, 32'h0000_0004);
      apb(1'b1, OFF_COUNT, 32'h0000_0000);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0007);
      pulse(6);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk("count after six ticks", 32'h0001_0002, rd_data);
      pulse(3);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk("count after nine ticks", 32'h0000_0001, rd_data);
      // Routed comparator replaces the channel 0 pin as capture source
      apb(1'b1, OFF_SYSTEM_OPTIONS, 32'h0000_0001);
      apb(1'b1, OFF_CHAN_BASE, 32'h0000_0086);
      ext_en[0] <= 1'b1;
      ext_val[0] <= 1'b1;
      repeat (3) @(posedge clk);
      ext_en[0] <= 1'b0;
      apb(1'b0, OFF_CHAN_BASE, 32'h0000_0000);
      chk("flag after pin edge", 32'h0000_0006, rd_data);
      cmp_out <= 1'b1;
      repeat (3) @(posedge clk);
      cmp_out <= 1'b0;
      apb(1'b0, OFF_CHAN_BASE, 32'h0000_0000);
      chk("flag after comparator edge", 32'h0000_0086, rd_data);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rd_err});
      chk("unmapped data", 32'h0000_0000, rd_data);
      // Free run at modulus zero; a new modulus waits for the wrap
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0000);
      apb(1'b1, OFF_MODULUS, 32'h0000_0000);
      apb(1'b1, OFF_COUNT, 32'h0000_0000);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0000_0001);
      apb(1'b1, OFF_MODULUS, 32'h0000_0005);
      repeat (100) @(posedge clk);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk("count past pending modulus", 32'h0000_0001, {31'h0000_0000, rd_data[15:0] > 16'h0005});
      repeat (65536) @(posedge clk);
      apb(1'b0, OFF_COUNT, 32'h0000_0000);
      chk("count under loaded modulus", 32'h0000_0001, {31'h0000_0000, rd_data[15:0] < 16'h0006});
      // Second reset in mid-run
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      chk("enables after reset", 32'h0000_0000, {30'h0000_0000, pin_oe});
      foreach (regs[k])
      begin
         apb(1'b0, regs[k], 32'h0000_0000);
         chk("reset value", 32'h0000_0000, rd_data);
      end
      report_and_stop();
   end
endmodule // cpt_timer_pwm_unit_tb

bind cpt_timer_pwm_unit cpt_pwm_props #(.NCH(NCH)) u_props (
   .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .EXTERNAL_TIMER_CLOCK_PIN(EXTERNAL_TIMER_CLOCK_PIN),
   .TIMER_EXTERNAL_CLOCK_TICK(TIMER_EXTERNAL_CLOCK_TICK),
   .ANALOG_COMPARATOR_OUT(ANALOG_COMPARATOR_OUT), .TIMER_CHANNEL_PIN_IN(TIMER_CHANNEL_PIN_IN),
   .TIMER_CHANNEL_PIN_OUT(TIMER_CHANNEL_PIN_OUT), .TIMER_CHANNEL_PIN_OE(TIMER_CHANNEL_PIN_OE));
`default_nettype wire
